// ===== line_mode_pkg.sv
package line_mode_pkg;
    // register byte offsets
    localparam logic [7:0]  ADDR_AFC      = 8'h00;
    localparam logic [7:0]  ADDR_LINE_CTL = 8'h04;
    localparam logic [7:0]  ADDR_OS_DIV   = 8'h08;
    localparam logic [7:0]  ADDR_STATUS   = 8'h0C;
    // alternate_function_config fields
    localparam int          AFC_IR_BIT    = 1;
    localparam int          AFC_485_BIT   = 2;
    localparam int          AFC_LG_BIT    = 3;
    localparam int          AFC_RCV_BIT   = 4;
    localparam int          AFC_DLY_LSB   = 5;
    localparam int          AFC_DLY_W     = 3;
    localparam logic [7:0]  AFC_RESET     = 8'h00;
    localparam logic [7:0]  AFC_WR_MASK   = 8'hFE;
    // line control and status fields
    localparam int          LC_LOOP_BIT   = 0;
    localparam int          ST_DE_BIT     = 0;
    localparam int          ST_HOLD_BIT   = 1;
    localparam int          ST_STORE_BIT  = 2;
    localparam int          ST_RXD_BIT    = 3;
    // oversample divider: one tick every (divisor + 1) clocks
    localparam int          OS_DIV_W      = 16;
    localparam logic [15:0] OS_DIV_RESET  = 16'h000D;
    // infrared timing in oversample ticks
    localparam int          OS_PER_BIT    = 16;
    localparam logic [3:0]  IR_PULSE_ON   = 4'h7;
    localparam logic [3:0]  IR_PULSE_OFF  = 4'hA;
    localparam logic [3:0]  IR_LOW_LAST   = 4'hF;
    localparam logic [3:0]  BIT_LAST      = 4'hF;

    typedef enum logic [2:0] {
        DE_IDLE   = 3'b001,
        DE_ACTIVE = 3'b010,
        DE_HOLD   = 3'b100
    } de_state_e;

    function automatic logic [3:0] inc4(input logic [3:0] v);
        return v + 4'h1;
    endfunction
endpackage

// ===== irda_if.sv
interface irda_if;
    logic tick;
    logic int_tx;
    logic ir_tx;
    logic ir_rx;
    logic int_rx;
    modport enc (input tick, input int_tx, output ir_tx);
    modport dec (input tick, input ir_rx, output int_rx);
    modport ctl (output tick, output int_tx, output ir_rx, input ir_tx, input int_rx);
endinterface

// ===== irda_encoder.sv
module irda_encoder import line_mode_pkg::*; (
    // clock and reset
    input  wire logic pclk,
    input  wire logic presetn,
    // codec link
    irda_if.enc       link
);
    logic [3:0] pulse_count;
    logic [3:0] next_count;

    assign next_count = inc4(pulse_count);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pulse_count <= 4'h0;
            link.ir_tx  <= 1'b0;
        end else if (link.int_tx) begin
            pulse_count <= 4'h0;
            link.ir_tx  <= 1'b0;
        end else if (link.tick) begin
            pulse_count <= next_count;
            // pulse spans the 7th through 9th tick of each bit
            link.ir_tx  <= (next_count >= IR_PULSE_ON) && (next_count < IR_PULSE_OFF);
        end
    end

    a_enc_idle_low: assert property (@(posedge pclk) disable iff (!presetn)
        link.int_tx |=> !link.ir_tx && pulse_count == 4'h0)
        else $error("encoder drove tx while serial data high");
endmodule

// ===== irda_decoder.sv
module irda_decoder import line_mode_pkg::*; (
    // clock and reset
    input  wire logic pclk,
    input  wire logic presetn,
    // codec link
    irda_if.dec       link
);
    logic       rx_prev;
    logic [3:0] low_count;

    // works on falling edges only, so a positive pulse decodes at its trailing edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_prev     <= 1'b1;
            low_count   <= 4'h0;
            link.int_rx <= 1'b1;
        end else if (link.tick) begin
            rx_prev <= link.ir_rx;
            if (rx_prev && !link.ir_rx) begin
                link.int_rx <= 1'b0;
                low_count   <= 4'h0;
            end else if (!link.int_rx) begin
                low_count <= inc4(low_count);
                if (low_count == IR_LOW_LAST) begin
                    link.int_rx <= 1'b1;
                end
            end
        end
    end

    a_dec_low_hold: assert property (@(posedge pclk) disable iff (!presetn)
        !link.tick |=> $stable(link.int_rx))
        else $error("decoded rx changed without an oversample tick");
endmodule

// ===== uart_line_mode.sv
// Function
// - three-bit delay field sets driver-enable hold time
// - delay starts when empty, cancelled by writes
// - enable rises bit before first stop
// - enable holds for delay, then drops
// - large-block: interrupt on threshold or empty
// - bus mode without large-block: interrupt when shift register empties
// - receive-while-send stores data, allows timeout
// - standard mode without it: no timeout interrupt
// - bus or infrared without it: nothing stored
// - loopback idles tx pin and decoder input, still stores looped data
// - infrared codec uses sixteen ticks per bit
// - one is no pulse, zero one pulse
// - high serial data holds tx low
// - low data gives pulse ticks seven to nine
// - reset sets decoded rx high, counter cleared
// - falling rx edge gives sixteen-tick low
// - core samples decoded data mid-bit
// - positive pulses decode at trailing edge
// - dedicated bit enables infrared mode
// - bus mode without large-block withholds interrupts until empty
// - bus mode without listen disables receiver
module uart_line_mode import line_mode_pkg::*; #(
    parameter int DIV_W = OS_DIV_W
) (
    // apb slave
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // transmitter status from the uart core
    input  wire logic        tx_shift_empty,
    input  wire logic        tx_fifo_empty,
    input  wire logic        tx_fifo_write,
    input  wire logic        tx_stop_next,
    input  wire logic        tx_thresh_cross,
    input  wire logic        tx_fifo_went_empty,
    input  wire logic        tx_level_above,
    input  wire logic        core_tx_data,
    // receiver controls to the uart core
    output logic             core_rx_data,
    output logic             rx_store_enable,
    output logic             rx_timeout_enable,
    output logic             tx_irq_event,
    output logic             oversample_tick,
    // line pins
    input  wire logic        rx_pin,
    output logic             tx_pin,
    output logic             driver_enable_output
);
    logic [7:0]       alternate_function_config;
    logic             loopback_bit;
    logic [DIV_W-1:0] os_divisor;
    logic [DIV_W-1:0] os_count;
    logic [3:0]       bit_phase;
    logic             bit_tick;
    logic [3:0]       hold_count;
    de_state_e        de_state;
    de_state_e        next_de_state;
    logic             shift_empty_d;

    logic             ir_mode;
    logic             bus_mode;
    logic             large_block;
    logic             listen;
    logic [2:0]       turnaround_delay;
    logic             tx_idle;
    logic             access;
    logic             mapped;

    irda_if ir ();

    assign ir_mode          = alternate_function_config[AFC_IR_BIT];
    assign bus_mode         = alternate_function_config[AFC_485_BIT];
    assign large_block      = alternate_function_config[AFC_LG_BIT];
    assign listen           = alternate_function_config[AFC_RCV_BIT];
    assign turnaround_delay = alternate_function_config[AFC_DLY_LSB +: AFC_DLY_W];
    assign tx_idle          = tx_shift_empty && tx_fifo_empty;
    assign access           = psel && penable && pready;
    assign mapped           = paddr == ADDR_AFC || paddr == ADDR_LINE_CTL
                           || paddr == ADDR_OS_DIV || paddr == ADDR_STATUS;

    // apb: no wait states, answer registered in the setup cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else begin
            pready  <= psel && !penable;
            pslverr <= psel && !penable && !mapped;
            if (psel && !penable && !pwrite) begin
                case (paddr)
                    ADDR_AFC:      prdata <= {24'h00_0000, alternate_function_config};
                    ADDR_LINE_CTL: prdata <= {31'h0000_0000, loopback_bit};
                    ADDR_OS_DIV:   prdata <= 32'(os_divisor);
                    ADDR_STATUS:   prdata <= {28'h000_0000, core_rx_data, rx_store_enable,
                                              de_state == DE_HOLD, driver_enable_output};
                    default:       prdata <= 32'h0000_0000;
                endcase
            end
        end
    end

    // config registers; writes land only at the completing edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            alternate_function_config <= AFC_RESET;
            loopback_bit              <= 1'b0;
            os_divisor                <= DIV_W'(OS_DIV_RESET);
        end else if (access && pwrite) begin
            case (paddr)
                ADDR_AFC:      alternate_function_config <= pwdata[7:0] & AFC_WR_MASK;
                ADDR_LINE_CTL: loopback_bit <= pwdata[LC_LOOP_BIT];
                ADDR_OS_DIV:   os_divisor <= pwdata[DIV_W-1:0];
                default:       ;
            endcase
        end
    end

    // oversample divider and bit-time divider
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            os_count        <= '0;
            oversample_tick <= 1'b0;
        end else if (os_count >= os_divisor) begin
            os_count        <= '0;
            oversample_tick <= 1'b1;
        end else begin
            os_count        <= os_count + 1'b1;
            oversample_tick <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bit_phase <= 4'h0;
            bit_tick  <= 1'b0;
        end else begin
            bit_tick <= oversample_tick && bit_phase == BIT_LAST;
            if (oversample_tick) begin
                bit_phase <= inc4(bit_phase);
            end
        end
    end

    // driver-enable sequencing
    always_comb begin
        next_de_state = de_state;
        case (de_state)
            DE_IDLE: begin
                if (bus_mode && tx_stop_next) begin
                    next_de_state = DE_ACTIVE;
                end
            end
            DE_ACTIVE: begin
                if (!bus_mode) begin
                    next_de_state = DE_IDLE;
                end else if (tx_idle && !tx_fifo_write) begin
                    // a zero delay releases the bus right away
                    next_de_state = (turnaround_delay == 3'h0) ? DE_IDLE : DE_HOLD;
                end
            end
            DE_HOLD: begin
                if (!bus_mode) begin
                    next_de_state = DE_IDLE;
                end else if (tx_fifo_write || !tx_idle) begin
                    next_de_state = DE_ACTIVE;
                end else if (bit_tick && hold_count + 4'h1 >= {1'b0, turnaround_delay}) begin
                    next_de_state = DE_IDLE;
                end
            end
            default: next_de_state = DE_IDLE;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            de_state             <= DE_IDLE;
            driver_enable_output <= 1'b0;
        end else begin
            de_state             <= next_de_state;
            driver_enable_output <= next_de_state != DE_IDLE;
        end
    end

    // delay counted in whole bit times, restarted each time the hold begins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hold_count <= 4'h0;
        end else if (de_state != DE_HOLD) begin
            hold_count <= 4'h0;
        end else if (bit_tick) begin
            hold_count <= inc4(hold_count);
        end
    end

    // transmit interrupt timing
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            shift_empty_d <= 1'b1;
            tx_irq_event  <= 1'b0;
        end else begin
            shift_empty_d <= tx_shift_empty;
            if (bus_mode && !large_block) begin
                tx_irq_event <= tx_shift_empty && !shift_empty_d;
            end else begin
                tx_irq_event <= tx_thresh_cross || (tx_fifo_went_empty && !tx_level_above);
            end
        end
    end

    // receive gating; the core strobes mid-bit so one-tick glitches pass unseen
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_store_enable   <= 1'b1;
            rx_timeout_enable <= 1'b0;
        end else begin
            rx_store_enable   <= listen || loopback_bit || !(bus_mode || ir_mode);
            rx_timeout_enable <= listen;
        end
    end

    // codec link and pin muxing; loopback parks tx_pin and the decoder input at their idle level
    assign ir.tick   = oversample_tick;
    assign ir.int_tx = core_tx_data;
    assign ir.ir_rx  = loopback_bit ? 1'b1 : rx_pin;

    irda_encoder u_enc (
        .pclk    (pclk),
        .presetn (presetn),
        .link    (ir.enc)
    );

    irda_decoder u_dec (
        .pclk    (pclk),
        .presetn (presetn),
        .link    (ir.dec)
    );

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_pin       <= 1'b1;
            core_rx_data <= 1'b1;
        end else begin
            if (loopback_bit) begin
                tx_pin <= !ir_mode;
            end else begin
                tx_pin <= ir_mode ? ir.ir_tx : core_tx_data;
            end
            if (loopback_bit) begin
                core_rx_data <= core_tx_data;
            end else begin
                core_rx_data <= ir_mode ? ir.int_rx : rx_pin;
            end
        end
    end

    sequence s_tx_drains;
        de_state == DE_ACTIVE && tx_idle && !tx_fifo_write && bus_mode;
    endsequence

    a_de_zero_drop: assert property (@(posedge pclk) disable iff (!presetn)
        s_tx_drains and turnaround_delay == 3'h0 |=> !driver_enable_output)
        else $error("driver enable stayed high with zero delay");

    a_de_hold_high: assert property (@(posedge pclk) disable iff (!presetn)
        s_tx_drains and turnaround_delay != 3'h0 |=> driver_enable_output && de_state == DE_HOLD)
        else $error("driver enable fell without turnaround delay");

    a_de_rise: assert property (@(posedge pclk) disable iff (!presetn)
        de_state == DE_IDLE && bus_mode && tx_stop_next |=> driver_enable_output)
        else $error("driver enable did not rise before stop bit");

    a_hold_cancel: assert property (@(posedge pclk) disable iff (!presetn)
        de_state == DE_HOLD && bus_mode && tx_fifo_write |=> de_state == DE_ACTIVE ##1 hold_count == 4'h0)
        else $error("fifo write did not cancel turnaround");

    a_de_busy_high: assert property (@(posedge pclk) disable iff (!presetn)
        driver_enable_output && bus_mode && !tx_idle |=> driver_enable_output)
        else $error("driver enable fell while data pending");

    a_irq_shift_only: assert property (@(posedge pclk) disable iff (!presetn)
        bus_mode && !large_block && $past(bus_mode) && $past(large_block) == 1'b0
        && tx_thresh_cross && !(tx_shift_empty && !shift_empty_d) |=> !tx_irq_event)
        else $error("transmit interrupt raised before shift register empty");

    a_no_store: assert property (@(posedge pclk) disable iff (!presetn)
        (bus_mode || ir_mode) && !listen && !loopback_bit |=> !rx_store_enable)
        else $error("receiver stored data in half-duplex mode");

    a_no_timeout: assert property (@(posedge pclk) disable iff (!presetn)
        !listen |=> !rx_timeout_enable)
        else $error("timeout interrupt allowed without listen bit");

    a_loop_pins: assert property (@(posedge pclk) disable iff (!presetn)
        loopback_bit ##1 loopback_bit |-> core_rx_data == $past(core_tx_data)
        && tx_pin == !$past(ir_mode))
        else $error("loopback did not isolate pins");

    a_irq_large: assert property (@(posedge pclk) disable iff (!presetn)
        (!bus_mode || large_block) && tx_thresh_cross |=> tx_irq_event)
        else $error("threshold crossing gave no transmit interrupt");

    a_irq_empty: assert property (@(posedge pclk) disable iff (!presetn)
        (!bus_mode || large_block) && tx_fifo_went_empty && !tx_level_above |=> tx_irq_event)
        else $error("fifo empty gave no transmit interrupt");

    a_irq_shift_rise: assert property (@(posedge pclk) disable iff (!presetn)
        bus_mode && !large_block && tx_shift_empty && !shift_empty_d |=> tx_irq_event)
        else $error("shift register empty gave no transmit interrupt");

    a_listen_store: assert property (@(posedge pclk) disable iff (!presetn)
        listen |=> rx_store_enable && rx_timeout_enable)
        else $error("receive-while-send did not enable the receiver");

    a_std_store: assert property (@(posedge pclk) disable iff (!presetn)
        !bus_mode && !ir_mode |=> rx_store_enable)
        else $error("standard mode receiver not storing");

    a_loop_store: assert property (@(posedge pclk) disable iff (!presetn)
        loopback_bit |=> rx_store_enable)
        else $error("loopback data not stored");

    a_ir_tx_idle: assert property (@(posedge pclk) disable iff (!presetn)
        core_tx_data ##1 (ir_mode && !loopback_bit) |=> !tx_pin)
        else $error("infrared tx pulsed while serial data high");

    a_tx_plain: assert property (@(posedge pclk) disable iff (!presetn)
        !ir_mode && !loopback_bit |=> tx_pin == $past(core_tx_data))
        else $error("plain mode tx not passed straight to the pin");

    a_rx_passthru: assert property (@(posedge pclk) disable iff (!presetn)
        !loopback_bit && !ir_mode |=> core_rx_data == $past(rx_pin))
        else $error("receive data not passed straight to the core");

    a_de_off_idle: assert property (@(posedge pclk) disable iff (!presetn)
        !bus_mode && de_state == DE_IDLE |=> !driver_enable_output)
        else $error("driver enable rose with bus mode off");
endmodule

// ===== line_partner.sv
module line_partner (
    // line side
    input  wire logic pclk,
    input  wire logic tx_pin,
    input  wire logic driver_enable_output,
    // optics stimulus
    input  wire logic send_pulse,
    input  wire logic pos_pol,
    output logic      rx_pin
);
    timeunit 1ns;
    timeprecision 1ps;

    int pulse_left = 0;

    // three-clock light pulse, as the optics would shape it
    always @(posedge pclk) begin
        if (send_pulse) begin
            pulse_left <= 3;
        end else if (pulse_left > 0) begin
            pulse_left <= pulse_left - 1;
        end
    end

    // released line rests at its biased idle level; while driving, our own echo returns
    always_comb begin
        if (driver_enable_output) begin
            rx_pin = tx_pin;
        end else begin
            rx_pin = (pulse_left > 0) ? pos_pol : !pos_pol;
        end
    end
endmodule

// ===== tb.sv
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import line_mode_pkg::*;

    logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata;
    logic        pready, pslverr, sh_empty = 1, ff_empty = 1, lvl_above = 0, ctx = 1;
    logic [3:0]  ev = 4'h0;
    logic        send_pulse = 0, pos_pol = 0;
    logic        core_rx_data, rx_store_enable, rx_timeout_enable, tx_irq_event;
    logic        oversample_tick, rx_pin, tx_pin, driver_enable_output;
    logic [15:0] lf = 16'h899E;
    logic [7:0]  modes[6] = '{8'h10, 8'h14, 8'h12, 8'h00, 8'h04, 8'h02};
    int          miscompares = 0, total_checks = 0;
    wire logic [4:0] mon = {oversample_tick, tx_irq_event, !core_rx_data, tx_pin,
                            driver_enable_output};

    uart_line_mode #(.DIV_W(16)) uart_line_mode_i (
        .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .tx_shift_empty(sh_empty), .tx_fifo_empty(ff_empty),
        .tx_fifo_write(ev[3]), .tx_stop_next(ev[0]), .tx_thresh_cross(ev[1]),
        .tx_fifo_went_empty(ev[2]), .tx_level_above(lvl_above), .core_tx_data(ctx),
        .core_rx_data, .rx_store_enable, .rx_timeout_enable, .tx_irq_event,
        .oversample_tick, .rx_pin, .tx_pin, .driver_enable_output);

    line_partner line_partner_i (.pclk, .tx_pin, .driver_enable_output, .send_pulse,
                                 .pos_pol, .rx_pin);

    always #20 pclk = !pclk;

    function automatic logic [15:0] lfsr(input logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction

    task automatic end_sim();
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] %0t value %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_rng(input int got, input int lo, input int hi);
        total_checks++;
        if (got < lo || got > hi) begin
            miscompares++;
            $display("[FAIL] %0t count %0d outside %0d..%0d", $time, got, lo, hi);
        end
    endtask

    // called just after a rising edge; returns one edge after the one that took pready
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] rd, output logic err);
        int n;
        psel <= 1;
        penable <= 0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n == 20) miscompares++;
        rd = prdata;
        err = pslverr;
        psel <= 0;
        penable <= 0;
        // one idle edge, so the next call never reassigns psel in this time step
        @(posedge pclk);
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge pclk);
    endtask

    task automatic ev_pulse(input int b);
        ev[b] <= 1;
        @(posedge pclk);
        ev <= 4'h0;
    endtask

    task automatic cnt(input int s, input int n, output int c);
        c = 0;
        repeat (n) begin
            @(posedge pclk);
            c += int'(mon[s] === 1'b1);
        end
    endtask

    task automatic hold_len(output int c);
        c = 0;
        while (driver_enable_output === 1'b1 && c < 400) begin
            @(posedge pclk);
            c++;
        end
    endtask

    initial begin
        #400000;
        miscompares++;
        end_sim();
    end

    initial begin
        int c;
        logic [31:0] r;
        logic e, lp;
        logic [7:0] cfg;
        logic [2:0] d;
        cyc(3);
        chk(tx_pin, 1);
        chk(core_rx_data, 1);
        presetn <= 1;
        @(posedge pclk);
        apb(0, ADDR_AFC, 0, r, e);
        chk(r, {24'h0, AFC_RESET});
        apb(0, ADDR_OS_DIV, 0, r, e);
        chk(r, {16'h0, OS_DIV_RESET});
        cnt(4, 28, c);
        chk_rng(c, 2, 2);
        apb(1, 8'h10, 32'hFFFFFFFF, r, e);
        chk(e, 1);
        apb(0, 8'h10, 0, r, e);
        chk(r, 0);
        chk(e, 1);
        lf = lfsr(lf);
        apb(1, ADDR_AFC, {24'h0, lf[7:0]}, r, e);
        apb(0, ADDR_AFC, 0, r, e);
        chk(r, {24'h0, lf[7:0] & AFC_WR_MASK});
        apb(1, ADDR_OS_DIV, 0, r, e);
        // every mode in both loopback states
        for (int i = 0; i < 12; i++) begin
            cfg = modes[i % 6];
            lp = (i >= 6);
            apb(1, ADDR_AFC, {24'h0, cfg}, r, e);
            apb(1, ADDR_LINE_CTL, {31'h0, lp}, r, e);
            cyc(2);
            chk(rx_store_enable, cfg[4] | lp | !(cfg[2] | cfg[1]));
            chk(rx_timeout_enable, cfg[4]);
            if (lp) begin
                lf = lfsr(lf);
                ctx <= lf[0];
                send_pulse <= 1;
                @(posedge pclk);
                send_pulse <= 0;
                cyc(4);
                chk(core_rx_data, ctx);
                chk(tx_pin, !cfg[1]);
            end
        end
        apb(1, ADDR_LINE_CTL, 0, r, e);
        ctx <= 1;
        for (int k = 0; k < 3; k++) begin
            lf = lfsr(lf);
            d = (k == 0) ? 3'h0 : (k == 1) ? 3'h7 : lf[2:0];
            apb(1, ADDR_AFC, {24'h0, d, 5'h04}, r, e);
            sh_empty <= 0;
            ff_empty <= 0;
            ev_pulse(0);
            @(posedge pclk);
            chk(driver_enable_output, 1);
            cyc(30);
            chk(driver_enable_output, 1);
            sh_empty <= 1;
            ff_empty <= 1;
            hold_len(c);
            chk_rng(c, (d == 0) ? 0 : 16 * d - 15, 16 * d + 2);
        end
        // a write during the hold must restart it
        // three bit times, so the hold outlasts the 20-cycle wait at any bit phase
        apb(1, ADDR_AFC, 32'h64, r, e);
        sh_empty <= 0;
        ev_pulse(0);
        sh_empty <= 1;
        cyc(20);
        ff_empty <= 0;
        ev_pulse(3);
        cyc(60);
        chk(driver_enable_output, 1);
        ff_empty <= 1;
        hold_len(c);
        chk_rng(c, 35, 50);
        apb(1, ADDR_AFC, 32'h00, r, e);
        ev_pulse(0);
        cyc(3);
        chk(driver_enable_output, 0);
        apb(1, ADDR_AFC, 32'h04, r, e);
        sh_empty <= 0;
        cyc(3);
        sh_empty <= 1;
        cnt(3, 6, c);
        chk_rng(c, 1, 1);
        ev_pulse(1);
        cnt(3, 5, c);
        chk_rng(c, 0, 0);
        apb(1, ADDR_AFC, 32'h0C, r, e);
        ev_pulse(1);
        cnt(3, 5, c);
        chk_rng(c, 1, 1);
        lvl_above <= 1;
        ev_pulse(2);
        cnt(3, 5, c);
        chk_rng(c, 0, 0);
        lvl_above <= 0;
        ev_pulse(2);
        cnt(3, 5, c);
        chk_rng(c, 1, 1);
        apb(1, ADDR_AFC, 32'h12, r, e);
        ctx <= 0;
        cyc(20);
        cnt(1, 64, c);
        chk_rng(c, 12, 12);
        ctx <= 1;
        cyc(4);
        cnt(1, 64, c);
        chk_rng(c, 0, 0);
        send_pulse <= 1;
        @(posedge pclk);
        send_pulse <= 0;
        cnt(2, 40, c);
        chk_rng(c, 16, 16);
        // switching the idle level itself gives one falling edge; let it expire
        pos_pol <= 1;
        cyc(30);
        send_pulse <= 1;
        @(posedge pclk);
        send_pulse <= 0;
        cnt(2, 40, c);
        chk_rng(c, 16, 16);
        end_sim();
    end
endmodule
